//--- hdl/isp_pkg.sv
package isp_pkg;

    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam real         SAMPLE_RATE_SPS = 819.2;
    localparam real         SYNC_DRDY_US    = 600.0;
    localparam real         FLASH_BACKUP_MS = 50.0;
    localparam int unsigned SAMPLE_CYC      = int'($floor(real'(CLK_HZ) / SAMPLE_RATE_SPS));
    localparam int unsigned SYNC_DRDY_CYC   = int'($floor(real'(CLK_HZ) * SYNC_DRDY_US / 1.0e6));
    localparam int unsigned FLASH_CYC       = int'($ceil(real'(CLK_HZ) * FLASH_BACKUP_MS / 1.0e3));
    localparam logic [7:0]  DRDY_PULSE_CYC  = 8'h10;

    localparam int unsigned FRAME_BITS = 16;
    localparam logic [3:0]  FRAME_LAST = 4'hf;
    localparam int unsigned REG_WORDS  = 32;

    // word index = lower byte address / 2
    localparam logic [4:0] IDX_FLASH_WRITE_COUNTER = 5'h00;
    localparam logic [4:0] IDX_SUPPLY    = 5'h01;
    localparam logic [4:0] IDX_AUX_ADC   = 5'h0b;
    localparam logic [4:0] IDX_CFG_FIRST = 5'h0d;
    localparam logic [4:0] IDX_GPIO      = 5'h19;
    localparam logic [4:0] IDX_MSC       = 5'h1a;
    localparam logic [4:0] IDX_SMPL      = 5'h1b;
    localparam logic [4:0] IDX_SENS      = 5'h1c;
    localparam logic [4:0] IDX_SLP       = 5'h1d;
    localparam logic [4:0] IDX_GLOB      = 5'h1f;

    localparam logic [15:0] RST_MSC  = 16'h0006;
    localparam logic [15:0] RST_SMPL = 16'h0001;
    localparam logic [15:0] RST_SENS = 16'h0402;

    localparam logic [15:0] BURST_CMD      = 16'h3e00;
    localparam int unsigned WR_BIT         = 15;
    localparam int unsigned GLOB_FLASH_BIT = 3;
    localparam int unsigned MSC_SYNC_BIT   = 4;
    localparam int unsigned GPIO_DIR_BIT   = 3;
    localparam int unsigned GPIO_DATA_BIT  = 11;
    localparam int unsigned NEW_BIT        = 15;
    localparam int unsigned ERR_BIT        = 14;
    localparam int unsigned DATA_W         = 14;

    typedef enum logic {
        MODE_FRAME = 1'b0,
        MODE_BURST = 1'b1
    } isp_mode_e;

    typedef struct packed {
        logic [4:0]        idx;
        logic              err;
        logic [DATA_W-1:0] data;
    } isp_smp_word_s;

    function automatic logic [15:0] isp_reg_reset(input logic [4:0] i);
        case (i)
            IDX_MSC:  return RST_MSC;
            IDX_SMPL: return RST_SMPL;
            IDX_SENS: return RST_SENS;
            default:  return 16'h0000;
        endcase
    endfunction : isp_reg_reset

endpackage : isp_pkg

//--- hdl/isp_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none

module isp_fifo
    import isp_pkg::*;
#(
    parameter int unsigned WIDTH = 20,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    // depth must be a power of two so the pointers wrap on their own
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    nxt_wr;
    logic [AW-1:0]    rd_ff;
    logic [AW-1:0]    nxt_rd;
    logic [AW:0]      cnt_ff;
    logic [AW:0]      nxt_cnt;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o  = mem_ff[rd_ff];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_comb
    begin
        nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
        nxt_cnt = cnt_ff;
        if (push && !pop)
        begin
            nxt_cnt = cnt_ff + 1'b1;
        end
        else if (pop && !push)
        begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else if (ce_i)
        begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
            if (push)
            begin
                mem_ff[wr_ff] <= in_data_i;
            end
        end
    end
endmodule : isp_fifo

module isp_spi_slave
    import isp_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC_P    = SAMPLE_CYC,
    parameter int unsigned SYNC_DRDY_CYC_P = SYNC_DRDY_CYC,
    parameter int unsigned FLASH_CYC_P     = FLASH_CYC,
    parameter int unsigned FIFO_DEPTH      = 16
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          ce_i,
    input  wire logic          sclk_i,
    input  wire logic          cs_n_i,
    input  wire logic          din_i,
    output logic               dout_o,
    output logic               data_ready_pin_o,
    input  wire logic          sync_clock_pin_i,
    output logic               sync_clock_pin_o,
    output logic               sync_clock_pin_oe_n_o,
    output logic               sample_req_o,
    input  wire logic          smp_valid_i,
    input  wire isp_smp_word_s smp_word_i,
    output logic               smp_ready_o,
    output logic               flash_busy_o
);
    logic [15:0]   regs_ff [REG_WORDS];
    logic [15:0]   nxt_regs [REG_WORDS];
    logic [2:0]    sclk_sy_ff;
    logic [1:0]    cs_sy_ff;
    logic [1:0]    din_sy_ff;
    logic [2:0]    sync_sy_ff;
    logic [15:0]   rx_ff;
    logic [15:0]   nxt_rx;
    logic [15:0]   tx_ff;
    logic [15:0]   nxt_tx;
    logic          dout_ff;
    logic          nxt_dout;
    logic [3:0]    bit_ff;
    logic [3:0]    nxt_bit;
    isp_mode_e     mode_ff;
    isp_mode_e     nxt_mode;
    logic [4:0]    bidx_ff;
    logic [4:0]    nxt_bidx;
    logic [31:0]   smp_tmr_ff;
    logic [31:0]   nxt_smp_tmr;
    logic [31:0]   sync_tmr_ff;
    logic [31:0]   nxt_sync_tmr;
    logic [31:0]   flash_tmr_ff;
    logic [31:0]   nxt_flash_tmr;
    logic [15:0]   flash_write_counter_ff;
    logic [15:0]   nxt_flash_write_counter;
    logic          req_ff;
    logic          nxt_req;
    logic          pend_ff;
    logic          nxt_pend;
    logic [7:0]    drdy_cnt_ff;
    logic [7:0]    nxt_drdy_cnt;
    logic          drdy_ff;
    logic          nxt_drdy;
    logic          pin_oe_n_ff;
    logic          nxt_pin_oe_n;
    logic          pin_o_ff;
    logic          nxt_pin_o;
    logic          sclk_rise;
    logic          sclk_fall;
    logic          cs_idle;
    logic          sync_en;
    logic          sync_rise;
    logic [15:0]   rx_word;
    logic [5:0]    wr_addr;
    logic          pop;
    logic          fifo_valid;
    isp_smp_word_s fifo_word;

    assign dout_o                = dout_ff;
    assign data_ready_pin_o      = drdy_ff;
    assign sample_req_o          = req_ff;
    assign flash_busy_o          = (flash_tmr_ff != '0);
    assign sync_clock_pin_o      = pin_o_ff;
    assign sync_clock_pin_oe_n_o = pin_oe_n_ff;

    // only the second and third stages are looked at
    assign sclk_rise = sclk_sy_ff[1] & ~sclk_sy_ff[2];
    assign sclk_fall = ~sclk_sy_ff[1] & sclk_sy_ff[2];
    assign cs_idle   = cs_sy_ff[1];
    assign sync_rise = sync_sy_ff[1] & ~sync_sy_ff[2];
    assign sync_en   = regs_ff[IDX_MSC][MSC_SYNC_BIT];
    // sample words only land between frames, so a read never tears
    assign pop       = fifo_valid & cs_idle;

    isp_fifo #(
        .WIDTH ($bits(isp_smp_word_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .in_valid_i  (smp_valid_i),
        .in_data_i   (smp_word_i),
        .in_ready_o  (smp_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_word),
        .out_ready_i (cs_idle)
    );

    function automatic logic is_output(input logic [5:0] i);
        return (i >= {1'b0, IDX_SUPPLY}) && (i <= {1'b0, IDX_AUX_ADC});
    endfunction : is_output

    // both byte addresses of a word land here; unmapped reads give zero
    function automatic logic [15:0] rd_word(input logic [5:0] i);
        logic [15:0] w;
        w = '0;
        if (i == {1'b0, IDX_FLASH_WRITE_COUNTER})
        begin
            w = flash_write_counter_ff;
        end
        else if (i < 6'(REG_WORDS) && i != {1'b0, IDX_SLP} && i != {1'b0, IDX_GLOB})
        begin
            w = regs_ff[i[4:0]];
        end
        if (i == {1'b0, IDX_GPIO} && !regs_ff[IDX_GPIO][GPIO_DIR_BIT])
        begin
            w[GPIO_DATA_BIT] = sync_sy_ff[1];
        end
        return w;
    endfunction : rd_word

    function automatic logic [31:0] period_cyc(input logic [7:0] code);
        logic [7:0] c;
        c = (code == 8'h00) ? 8'h01 : code;
        return 32'(SAMPLE_CYC_P) * {24'h000000, c};
    endfunction : period_cyc

    always_comb
    begin
        nxt_regs      = regs_ff;
        nxt_rx        = rx_ff;
        nxt_tx        = tx_ff;
        nxt_dout      = dout_ff;
        nxt_bit       = bit_ff;
        nxt_mode      = mode_ff;
        nxt_bidx      = bidx_ff;
        nxt_smp_tmr   = smp_tmr_ff;
        nxt_sync_tmr  = sync_tmr_ff;
        nxt_flash_tmr = flash_tmr_ff;
        nxt_flash_write_counter = flash_write_counter_ff;
        nxt_req       = 1'b0;
        nxt_pend      = pend_ff;
        nxt_drdy_cnt  = drdy_cnt_ff;
        rx_word       = {rx_ff[14:0], din_sy_ff[1]};
        wr_addr       = rx_word[13:8];

        if (cs_idle)
        begin
            nxt_bit  = '0;
            nxt_mode = MODE_FRAME;
        end
        else
        begin
            if (sclk_rise)
            begin
                nxt_rx  = rx_word;
                nxt_bit = bit_ff + 1'b1;
                if (bit_ff == FRAME_LAST)
                begin
                    if (mode_ff == MODE_BURST && bidx_ff <= IDX_AUX_ADC)
                    begin
                        nxt_tx                    = rd_word({1'b0, bidx_ff});
                        nxt_regs[bidx_ff][NEW_BIT] = 1'b0;
                        nxt_bidx                  = bidx_ff + 1'b1;
                    end
                    else if (rx_word == BURST_CMD)
                    begin
                        nxt_mode                     = MODE_BURST;
                        nxt_tx                       = rd_word({1'b0, IDX_SUPPLY});
                        nxt_regs[IDX_SUPPLY][NEW_BIT] = 1'b0;
                        nxt_bidx                     = IDX_SUPPLY + 1'b1;
                    end
                    else if (rx_word[WR_BIT])
                    begin
                        nxt_mode = MODE_FRAME;
                        nxt_tx   = '0;
                        // byte lands only now, at the frame's last edge
                        if (wr_addr[5:1] >= IDX_CFG_FIRST)
                        begin
                            if (wr_addr[0])
                            begin
                                nxt_regs[wr_addr[5:1]][15:8] = rx_word[7:0];
                            end
                            else
                            begin
                                nxt_regs[wr_addr[5:1]][7:0] = rx_word[7:0];
                            end
                        end
                        // only an explicit command backs up, never a plain write
                        if (wr_addr == {IDX_GLOB, 1'b0} && rx_word[GLOB_FLASH_BIT] && flash_tmr_ff == '0)
                        begin
                            nxt_flash_tmr = 32'(FLASH_CYC_P);
                        end
                    end
                    else
                    begin
                        nxt_mode = MODE_FRAME;
                        nxt_tx   = rd_word(rx_word[14:9]);
                        if (is_output(rx_word[14:9]))
                        begin
                            nxt_regs[rx_word[13:9]][NEW_BIT] = 1'b0;
                        end
                    end
                end
            end
            if (sclk_fall)
            begin
                nxt_dout = tx_ff[15];
                nxt_tx   = {tx_ff[14:0], 1'b0};
            end
        end

        // sample pacing: internal timer or external sync edge
        if (sync_en)
        begin
            nxt_smp_tmr = period_cyc(regs_ff[IDX_SMPL][7:0]);
            if (sync_rise)
            begin
                nxt_req      = 1'b1;
                nxt_sync_tmr = 32'(SYNC_DRDY_CYC_P);
            end
        end
        else if (smp_tmr_ff <= 32'h00000001)
        begin
            nxt_req     = 1'b1;
            nxt_smp_tmr = period_cyc(regs_ff[IDX_SMPL][7:0]);
        end
        else
        begin
            nxt_smp_tmr = smp_tmr_ff - 1'b1;
        end
        if (!sync_rise && sync_tmr_ff != '0)
        begin
            nxt_sync_tmr = sync_tmr_ff - 1'b1;
        end

        // update after any read clear so a new sample always wins
        if (pop && is_output({1'b0, fifo_word.idx}))
        begin
            nxt_regs[fifo_word.idx] = {1'b1, fifo_word.err, fifo_word.data};
            if (fifo_word.idx == IDX_AUX_ADC)
            begin
                nxt_pend = 1'b1;
            end
        end

        if (pend_ff && drdy_cnt_ff == '0 && (!sync_en || sync_tmr_ff == '0))
        begin
            nxt_pend     = 1'b0;
            nxt_drdy_cnt = DRDY_PULSE_CYC;
        end
        else if (drdy_cnt_ff != '0)
        begin
            nxt_drdy_cnt = drdy_cnt_ff - 1'b1;
        end
        nxt_drdy = (nxt_drdy_cnt != '0);

        if (flash_tmr_ff == 32'h00000001)
        begin
            nxt_flash_write_counter = flash_write_counter_ff + 1'b1;
        end
        if (flash_tmr_ff != '0)
        begin
            nxt_flash_tmr = flash_tmr_ff - 1'b1;
        end

        nxt_pin_oe_n = ~(regs_ff[IDX_GPIO][GPIO_DIR_BIT] & ~sync_en);
        nxt_pin_o    = regs_ff[IDX_GPIO][GPIO_DATA_BIT];
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < REG_WORDS; i++)
            begin
                regs_ff[i] <= isp_reg_reset(5'(i));
            end
            sclk_sy_ff   <= 3'h7;
            cs_sy_ff     <= 2'h3;
            din_sy_ff    <= 2'h0;
            sync_sy_ff   <= 3'h0;
            rx_ff        <= '0;
            tx_ff        <= '0;
            dout_ff      <= 1'b0;
            bit_ff       <= '0;
            mode_ff      <= MODE_FRAME;
            bidx_ff      <= IDX_SUPPLY;
            smp_tmr_ff   <= 32'(SAMPLE_CYC_P);
            sync_tmr_ff  <= '0;
            flash_tmr_ff <= '0;
            flash_write_counter_ff <= '0;
            req_ff       <= 1'b0;
            pend_ff      <= 1'b0;
            drdy_cnt_ff  <= '0;
            drdy_ff      <= 1'b0;
            pin_oe_n_ff  <= 1'b1;
            pin_o_ff     <= 1'b0;
        end
        else if (ce_i)
        begin
            regs_ff      <= nxt_regs;
            sclk_sy_ff   <= {sclk_sy_ff[1:0], sclk_i};
            cs_sy_ff     <= {cs_sy_ff[0], cs_n_i};
            din_sy_ff    <= {din_sy_ff[0], din_i};
            sync_sy_ff   <= {sync_sy_ff[1:0], sync_clock_pin_i};
            rx_ff        <= nxt_rx;
            tx_ff        <= nxt_tx;
            dout_ff      <= nxt_dout;
            bit_ff       <= nxt_bit;
            mode_ff      <= nxt_mode;
            bidx_ff      <= nxt_bidx;
            smp_tmr_ff   <= nxt_smp_tmr;
            sync_tmr_ff  <= nxt_sync_tmr;
            flash_tmr_ff <= nxt_flash_tmr;
            flash_write_counter_ff <= nxt_flash_write_counter;
            req_ff       <= nxt_req;
            pend_ff      <= nxt_pend;
            drdy_cnt_ff  <= nxt_drdy_cnt;
            drdy_ff      <= nxt_drdy;
            pin_oe_n_ff  <= nxt_pin_oe_n;
            pin_o_ff     <= nxt_pin_o;
        end
    end

endmodule : isp_spi_slave

`default_nettype wire

//--- test/isp_smp_model.sv
`timescale 1ns/1ps
`default_nettype none
module isp_smp_model
    import isp_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     rst_n_i,
    input  wire logic     en_i,
    input  wire logic     req_i,
    input  wire logic     ready_i,
    output logic          valid_o,
    output isp_smp_word_s word_o,
    output logic [8:0]    seq_o
);
    // two idle cycles a word; stalls on ready low
    initial
    begin
        valid_o = 1'b0;
        word_o  = '1;
        seq_o   = '0;
        forever
        begin
            @(posedge clk_i);
            if (req_i && en_i && rst_n_i)
            begin
                for (int i = 1; i <= 11; i++)
                begin
                    repeat (2) @(posedge clk_i);
                    valid_o <= 1'b1;
                    word_o  <= '{idx: 5'(i), err: (i == 3), data: {seq_o, 5'(i)}};
                    @(posedge clk_i);
                    while (!ready_i) @(posedge clk_i);
                    valid_o <= 1'b0;
                    word_o  <= ~word_o; // stale word must not look valid
                end
                seq_o <= seq_o + 9'h001;
            end
        end
    end
endmodule : isp_smp_model
`default_nettype wire

//--- test/isp_spi_slave_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module isp_spi_slave_asserts
    import isp_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC_P    = SAMPLE_CYC,
    parameter int unsigned SYNC_DRDY_CYC_P = SYNC_DRDY_CYC,
    parameter int unsigned FLASH_CYC_P     = FLASH_CYC,
    parameter int unsigned FIFO_DEPTH      = 16
) (
    input wire logic          clk_i,
    input wire logic          rst_n_i,
    input wire logic          ce_i,
    input wire logic          sclk_i,
    input wire logic          cs_n_i,
    input wire logic          din_i,
    input wire logic          dout_o,
    input wire logic          data_ready_pin_o,
    input wire logic          sync_clock_pin_i,
    input wire logic          sync_clock_pin_o,
    input wire logic          sync_clock_pin_oe_n_o,
    input wire logic          sample_req_o,
    input wire logic          smp_valid_i,
    input wire isp_smp_word_s smp_word_i,
    input wire logic          smp_ready_o,
    input wire logic          flash_busy_o
);
    logic [7:0]  sclk_h_ff;
    logic [31:0] up_cnt_ff;
    logic [31:0] busy_cnt_ff;
    logic        first_ff;
    logic [3:0]  aux_cnt_ff;
    logic        fell_near;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    assign fell_near = |(~sclk_h_ff[6:1] & sclk_h_ff[7:2]);
    always_ff @(posedge clk_i)
    begin
        sclk_h_ff   <= {sclk_h_ff[6:0], sclk_i};
        up_cnt_ff   <= rst_n_i ? up_cnt_ff + 32'h1 : 32'h0;
        busy_cnt_ff <= flash_busy_o ? busy_cnt_ff + 32'h1 : 32'h0;
        first_ff    <= !rst_n_i ? 1'b1 : (sample_req_o ? 1'b0 : first_ff);
        // counted, since the next sample's last word may land during a pulse
        if (!rst_n_i)
        begin
            aux_cnt_ff <= 4'h0;
        end
        else
        begin
            aux_cnt_ff <= aux_cnt_ff + 4'(smp_valid_i && smp_ready_o && smp_word_i.idx == IDX_AUX_ADC)
                - 4'($rose(data_ready_pin_o));
        end
    end
    drdy_pulse_a: assert property ($rose(data_ready_pin_o) |-> data_ready_pin_o[*8] ##1 data_ready_pin_o[*8]
        ##1 !data_ready_pin_o) else $error("data ready pulse not 16 cycles");
    drdy_cause_a: assert property ($rose(data_ready_pin_o) |-> aux_cnt_ff != 4'h0)
        else $error("data ready before full sample");
    dout_edge_a: assert property ($changed(dout_o) |-> fell_near) else $error("dout moved without sclk fall");
    cs_hold_a: assert property (cs_n_i[*8] |-> $stable(dout_o)) else $error("dout moved while deselected");
    req_once_a: assert property (sample_req_o |=> !sample_req_o) else $error("sample request longer than one cycle");
    first_req_a: assert property (sample_req_o && first_ff |->
        up_cnt_ff inside {[SAMPLE_CYC_P - 2 : SAMPLE_CYC_P + 2]}) else $error("first sample request off time");
    flash_len_a: assert property ($fell(flash_busy_o) |->
        busy_cnt_ff inside {[FLASH_CYC_P - 1 : FLASH_CYC_P + 1]}) else $error("flash busy wrong length");
    reset_out_a: assert property (!$past(rst_n_i) |-> sync_clock_pin_oe_n_o && !flash_busy_o
        && !data_ready_pin_o && !sample_req_o) else $error("outputs not idle after reset");
endmodule : isp_spi_slave_asserts
bind isp_spi_slave isp_spi_slave_asserts #(.SAMPLE_CYC_P(SAMPLE_CYC_P), .SYNC_DRDY_CYC_P(SYNC_DRDY_CYC_P),
    .FLASH_CYC_P(FLASH_CYC_P), .FIFO_DEPTH(FIFO_DEPTH)) u_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ce_i(ce_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i), .dout_o(dout_o),
    .data_ready_pin_o(data_ready_pin_o), .sync_clock_pin_i(sync_clock_pin_i), .sync_clock_pin_o(sync_clock_pin_o),
    .sync_clock_pin_oe_n_o(sync_clock_pin_oe_n_o), .sample_req_o(sample_req_o), .smp_valid_i(smp_valid_i),
    .smp_word_i(smp_word_i), .smp_ready_o(smp_ready_o), .flash_busy_o(flash_busy_o));
`default_nettype wire

//--- test/tb_isp_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none
module tb_isp_spi_slave;
    import isp_pkg::*;
    localparam int unsigned SYNC_P = 50;
    logic          clk, rst_n, sclk, cs_n, din, sync_drv, en;
    wire logic     dout, drdy, sync_w, pin_o, oe_n, req, sv, sr, busy;
    isp_smp_word_s sw;
    logic [8:0]    seq;
    int            errors, compares, cyc;
    assign sync_w = !oe_n ? pin_o : sync_drv;
    isp_spi_slave #(.SAMPLE_CYC_P(400), .SYNC_DRDY_CYC_P(SYNC_P), .FLASH_CYC_P(1000), .FIFO_DEPTH(16)) dut (
        .clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .dout_o(dout),
        .data_ready_pin_o(drdy), .sync_clock_pin_i(sync_w), .sync_clock_pin_o(pin_o),
        .sync_clock_pin_oe_n_o(oe_n), .sample_req_o(req), .smp_valid_i(sv), .smp_word_i(sw),
        .smp_ready_o(sr), .flash_busy_o(busy));
    isp_smp_model u_eng (.clk_i(clk), .rst_n_i(rst_n), .en_i(en), .req_i(req), .ready_i(sr),
        .valid_o(sv), .word_o(sw), .seq_o(seq));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        if (errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // mode 3 master; reads dout late in the high phase
    task automatic frame(input logic [15:0] tx, input int nb, input bit hold, output logic [15:0] rx);
        @(negedge clk);
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 15; i > 15 - nb; i--)
        begin
            sclk = 1'b0;
            din  = tx[i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            rx[i] = dout;
        end
        if (hold)
            repeat (7) @(negedge clk);
        else
        begin
            cs_n = 1'b1;
            repeat (360) @(negedge clk);
        end
    endtask : frame
    task automatic xfer(input logic [15:0] tx, input logic [15:0] e, input bit c);
        logic [15:0] rx;
        frame(tx, 16, 1'b0, rx);
        if (c)
            chk(rx, e);
    endtask : xfer
    task automatic wait_rdy(output int n);
        for (n = 0; n < 3000 && drdy !== 1'b1; n++) @(negedge clk);
        chk({15'h0, drdy}, 16'h1);
        repeat (20) @(negedge clk);
    endtask : wait_rdy
    function automatic logic [15:0] w(input int i, input bit nd);
        return {nd, i == 3, 9'(seq - 9'h001), 5'(i)};
    endfunction : w
    task automatic t_config();
        xfer(16'h3400, 16'h0, 1'b0);
        xfer(16'h3600, 16'h0006, 1'b1);
        xfer(16'h3800, 16'h0001, 1'b1);
        xfer(16'h0000, 16'h0402, 1'b1);
        xfer(16'h0000, 16'h0000, 1'b1);
    endtask : t_config
    task automatic t_sample();
        int n;
        en = 1'b1;
        wait_rdy(n);
        en = 1'b0;
        xfer(16'h0200, 16'h0, 1'b0);
        xfer(16'h0300, w(1, 1'b1), 1'b1);
        xfer(16'h0600, w(1, 1'b0), 1'b1);
        xfer(16'h0000, w(3, 1'b1), 1'b1);
    endtask : t_sample
    task automatic t_burst();
        int          n;
        logic [15:0] rx;
        en = 1'b1;
        wait_rdy(n);
        en = 1'b0;
        frame(16'h3e00, 16, 1'b1, rx);
        for (int i = 1; i <= 11; i++)
        begin
            frame(16'h0000, 16, i < 11, rx);
            chk(rx, w(i, 1'b1));
        end
    endtask : t_burst
    task automatic t_fifo();
        int n;
        cs_n = 1'b0;
        en   = 1'b1;
        for (n = 0; n < 3000 && sr !== 1'b0; n++) @(negedge clk);
        chk({15'h0, sr}, 16'h0);
        cs_n = 1'b1;
        wait_rdy(n);
        en = 1'b0;
        repeat (900) @(negedge clk);
    endtask : t_fifo
    task automatic t_write();
        logic [15:0] rx;
        xfer(16'h9a5a, 16'h0, 1'b0);
        xfer(16'h9b3c, 16'h0, 1'b0);
        frame(16'h9a11, 8, 1'b0, rx);
        xfer(16'h1a00, 16'h0, 1'b0);
        xfer(16'h0000, 16'h3c5a, 1'b1);
    endtask : t_write
    task automatic t_flash();
        int n;
        xfer(16'hbe08, 16'h0, 1'b1);
        chk({15'h0, busy}, 16'h1);
        for (n = 0; n < 1200 && busy !== 1'b0; n++) @(negedge clk);
        xfer(16'h0000, 16'h0, 1'b0);
        xfer(16'h0000, 16'h0001, 1'b1);
    endtask : t_flash
    task automatic t_sync();
        int n;
        xfer(16'hb208, 16'h0, 1'b0);
        xfer(16'hb308, 16'h0, 1'b0);
        chk({14'h0, oe_n, pin_o}, 16'h1);
        xfer(16'hb416, 16'h0, 1'b0);
        chk({15'h0, oe_n}, 16'h1);
        en       = 1'b1;
        sync_drv = 1'b1;
        repeat (10) @(negedge clk);
        sync_drv = 1'b0;
        wait_rdy(n);
        chk({15'h0, n + 10 >= SYNC_P && n + 10 <= SYNC_P + 150}, 16'h1);
    endtask : t_sync
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            errors++;
            close_out();
        end
    end
    initial
    begin
        rst_n    = 1'b0;
        sclk     = 1'b1;
        cs_n     = 1'b1;
        din      = 1'b0;
        sync_drv = 1'b0;
        en       = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_config();
        t_sample();
        t_burst();
        t_fifo();
        t_write();
        t_flash();
        t_sync();
        close_out();
    end
endmodule : tb_isp_spi_slave
`default_nettype wire
